// [core/alu_flags_core.sv]
// Flag-updating ALU datapath with pointer, stack and memory-space logic.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Memory-space select bit in flags routes all later memory accesses except memory-to-memory.
// - Memory-to-memory post-increment takes both maps from the command.
// - Register operands usable as 8 or 16 bit data or pointers.
// - Short immediates/offsets 8 bits; long ones and addresses 16 bits.
// - Bit operands select bit 0 to 7 of a byte.
// - Pre-decrement adjusts pointer before access; post-increment after.
// - Block transfers with post-increment pointers are byte loads only.
// - Byte add with or without carry: C Z S V H updated, D cleared.
// - Byte subtract with or without borrow: C Z S V H updated, D set.
// - Logic and test-mask: C kept, Z S updated, V cleared.
// - Byte shift left: C Z S H updated, V D cleared.
// - Shift right: byte clears D; word keeps D, clears V.
// - Rotate through carry: C S V updated, Z byte only, D H kept.
// - 16/8 divide sets C and D, updates Z S.
// - Two independent stacks with push, word push, address push, pop.
// - Bit operations on any register bit leave flags unchanged.
// - Datapath handles bits, nibbles, bytes and words.
// - Flags live in register 231; bit 0 mirrored on a pin.
module alu_flags_core
    import alu_flags_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic memory_space_select,
    output logic [15:0] mem_addr_ff,
    output logic src_space_ff,
    output logic dst_space_ff
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [15:0] opa_ff;
    logic [15:0] opb_ff;
    logic [31:0] cmd_ff;
    logic [15:0] result_ff;
    logic [7:0] flags_ff;
    logic [15:0] ptr_ff;
    logic [15:0] ssp_ff;
    logic [15:0] usp_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic sel_ff;

    logic wr_go;
    logic rd_go;
    logic go;
    logic [15:0] nxt_result;
    logic [7:0] nxt_flags;
    logic [15:0] nxt_ptr;
    logic [15:0] nxt_addr;
    logic addr_hit;

    op_type op;
    mode_type mode;
    logic word;
    logic [2:0] bsel;
    logic [2:0] sbsel;

    // Writes commit at the completing edge, when pready is sampled high.
    assign wr_go = psel && penable && pwrite && pready_ff;
    assign rd_go = psel && penable && !pwrite && !pready_ff;
    assign go = wr_go && paddr == OFS_CMD;
    assign op = op_type'(pwdata[CMD_OP_LSB +: 5]);
    assign mode = mode_type'(pwdata[CMD_MODE_LSB +: 4]);
    assign word = pwdata[CMD_WORD_BIT];
    assign bsel = pwdata[CMD_BIT_LSB +: 3];
    assign sbsel = pwdata[CMD_SBIT_LSB +: 3];
    assign addr_hit = paddr == OFS_OPA || paddr == OFS_OPB || paddr == OFS_CMD
        || paddr == OFS_RESULT || paddr == OFS_FLAGS || paddr == OFS_PTR
        || paddr == OFS_SSP || paddr == OFS_USP;

    // ------------------------------------------------------------------
    // Arithmetic and flag update
    // ------------------------------------------------------------------
    always_comb begin
        logic [16:0] sum;
        logic [4:0] nib;
        logic cin;
        logic [15:0] bv;
        logic [15:0] res;
        logic msb;
        logic bit_a;
        logic bit_b;
        sum = 17'h00000;
        nib = 5'h00;
        cin = 1'b0;
        bv = opb_ff;
        res = 16'h0000;
        msb = 1'b0;
        bit_a = opa_ff[bsel];
        bit_b = opb_ff[sbsel];
        nxt_flags = flags_ff;
        nxt_result = result_ff;
        case (op)
            OP_ADD, OP_ADC, OP_SUB, OP_SUBC: begin
                cin = (op == OP_ADC || op == OP_SUBC) ? flags_ff[FB_C] : 1'b0;
                if (op == OP_SUB || op == OP_SUBC) begin
                    bv = ~opb_ff;
                    cin = ~cin;
                end
                if (word) begin
                    sum = {1'b0, opa_ff} + {1'b0, bv} + {16'h0000, cin};
                    res = sum[15:0];
                    msb = res[15];
                    nxt_flags[FB_C] = sum[16] ^ (op == OP_SUB || op == OP_SUBC);
                    nxt_flags[FB_V] = (opa_ff[15] == bv[15]) && (msb != opa_ff[15]);
                end else begin
                    sum = {9'h000, opa_ff[7:0]} + {9'h000, bv[7:0]} + {16'h0000, cin};
                    res = {8'h00, sum[7:0]};
                    msb = res[7];
                    nib = {1'b0, opa_ff[3:0]} + {1'b0, bv[3:0]} + {4'h0, cin};
                    nxt_flags[FB_C] = sum[8] ^ (op == OP_SUB || op == OP_SUBC);
                    nxt_flags[FB_V] = (opa_ff[7] == bv[7]) && (msb != opa_ff[7]);
                    nxt_flags[FB_H] = nib[4] ^ (op == OP_SUB || op == OP_SUBC);
                    nxt_flags[FB_D] = (op == OP_SUB || op == OP_SUBC);
                end
                nxt_flags[FB_Z] = (word ? res : {8'h00, res[7:0]}) == 16'h0000;
                nxt_flags[FB_S] = msb;
                nxt_result = res;
            end
            OP_AND, OP_OR, OP_XOR, OP_TM: begin
                res = (op == OP_OR) ? (opa_ff | opb_ff) :
                      (op == OP_XOR) ? (opa_ff ^ opb_ff) : (opa_ff & opb_ff);
                if (!word) begin
                    res = {8'h00, res[7:0]};
                end
                nxt_flags[FB_Z] = res == 16'h0000;
                nxt_flags[FB_S] = word ? res[15] : res[7];
                nxt_flags[FB_V] = 1'b0;
                if (op != OP_TM) begin
                    nxt_result = res;
                end
            end
            OP_SHL: begin
                res = word ? {opa_ff[14:0], 1'b0} : {8'h00, opa_ff[6:0], 1'b0};
                nxt_flags[FB_C] = word ? opa_ff[15] : opa_ff[7];
                nxt_flags[FB_Z] = res == 16'h0000;
                nxt_flags[FB_S] = word ? res[15] : res[7];
                nxt_flags[FB_V] = 1'b0;
                if (!word) begin
                    nxt_flags[FB_D] = 1'b0;
                    nxt_flags[FB_H] = opa_ff[3];
                end
                nxt_result = res;
            end
            OP_SHR: begin
                res = word ? {opa_ff[15], opa_ff[15:1]} : {8'h00, opa_ff[7], opa_ff[7:1]};
                nxt_flags[FB_C] = opa_ff[0];
                nxt_flags[FB_S] = word ? res[15] : res[7];
                nxt_flags[FB_V] = 1'b0;
                nxt_flags[FB_H] = opa_ff[4];
                if (!word) begin
                    nxt_flags[FB_Z] = res == 16'h0000;
                    nxt_flags[FB_D] = 1'b0;
                end
                nxt_result = res;
            end
            OP_RORC, OP_ROLC: begin
                if (op == OP_RORC) begin
                    res = word ? {flags_ff[FB_C], opa_ff[15:1]} :
                        {8'h00, flags_ff[FB_C], opa_ff[7:1]};
                    nxt_flags[FB_C] = opa_ff[0];
                end else begin
                    res = word ? {opa_ff[14:0], flags_ff[FB_C]} :
                        {8'h00, opa_ff[6:0], flags_ff[FB_C]};
                    nxt_flags[FB_C] = word ? opa_ff[15] : opa_ff[7];
                end
                msb = word ? res[15] : res[7];
                nxt_flags[FB_S] = msb;
                nxt_flags[FB_V] = msb ^ (word ? opa_ff[15] : opa_ff[7]);
                if (!word) begin
                    nxt_flags[FB_Z] = res == 16'h0000;
                end
                nxt_result = res;
            end
            OP_DIV: begin
                if (opb_ff[7:0] != 8'h00) begin
                    res[7:0] = 8'((opa_ff / {8'h00, opb_ff[7:0]}));
                    res[15:8] = 8'((opa_ff % {8'h00, opb_ff[7:0]}));
                end else begin
                    res = 16'hFFFF;
                end
                nxt_flags[FB_C] = 1'b1;
                nxt_flags[FB_D] = 1'b1;
                nxt_flags[FB_Z] = res[7:0] == 8'h00;
                nxt_flags[FB_S] = res[7];
                nxt_result = res;
            end
            OP_DIVSTEP: begin
                nxt_result = {opa_ff[14:0], 1'b0} - opb_ff;
            end
            OP_BITLD, OP_BAND, OP_BOR, OP_BXOR: begin
                res = opa_ff;
                res[bsel] = (op == OP_BITLD) ? bit_b : (op == OP_BAND) ? (bit_a & bit_b) :
                    (op == OP_BOR) ? (bit_a | bit_b) : (bit_a ^ bit_b);
                nxt_result = res;
            end
            OP_SEL_PROG: nxt_flags[FB_SEL] = 1'b0;
            OP_SEL_DATA: nxt_flags[FB_SEL] = 1'b1;
            default: nxt_result = result_ff;
        endcase
    end

    // ------------------------------------------------------------------
    // Pointer adjustment and memory address
    // ------------------------------------------------------------------
    always_comb begin
        nxt_ptr = ptr_ff;
        nxt_addr = ptr_ff;
        case (mode)
            AM_PREDEC: begin
                nxt_ptr = word ? ptr_ff - 16'h0002 : ptr_ff - 16'h0001;
                nxt_addr = nxt_ptr;
            end
            AM_POSTINC, AM_M2M: begin
                nxt_ptr = (word && mode == AM_POSTINC) ? ptr_ff + 16'h0002 :
                    ptr_ff + 16'h0001;
            end
            AM_IDX_SHORT: nxt_addr = ptr_ff + {8'h00, opb_ff[7:0]};
            AM_IDX_LONG: nxt_addr = ptr_ff + opb_ff;
            default: nxt_addr = ptr_ff;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ptr_ff <= PTR_RST;
            mem_addr_ff <= 16'h0000;
            src_space_ff <= 1'b0;
            dst_space_ff <= 1'b0;
        end else if (wr_go && paddr == OFS_PTR) begin
            ptr_ff <= pwdata[15:0];
        end else if (go && mode != AM_NONE) begin
            ptr_ff <= nxt_ptr;
            mem_addr_ff <= nxt_addr;
            if (mode == AM_M2M) begin
                src_space_ff <= pwdata[CMD_SMAP_BIT];
                dst_space_ff <= pwdata[CMD_DMAP_BIT];
            end else begin
                src_space_ff <= flags_ff[FB_SEL];
                dst_space_ff <= flags_ff[FB_SEL];
            end
        end
    end

    // ------------------------------------------------------------------
    // Operands, result, flags and stacks
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            opa_ff <= 16'h0000;
            opb_ff <= 16'h0000;
            cmd_ff <= 32'h00000000;
            result_ff <= 16'h0000;
            flags_ff <= FLAGS_RST;
        end else if (wr_go) begin
            case (paddr)
                OFS_OPA: opa_ff <= pwdata[15:0];
                OFS_OPB: opb_ff <= pwdata[15:0];
                OFS_FLAGS: flags_ff <= pwdata[7:0];
                OFS_CMD: begin
                    cmd_ff <= pwdata;
                    result_ff <= nxt_result;
                    flags_ff <= nxt_flags;
                end
                default: cmd_ff <= cmd_ff;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            ssp_ff <= SP_RST;
            usp_ff <= SP_RST;
        end else if (wr_go && paddr == OFS_SSP) begin
            ssp_ff <= pwdata[15:0];
        end else if (wr_go && paddr == OFS_USP) begin
            usp_ff <= pwdata[15:0];
        end else if (go) begin
            case (op)
                OP_PUSH_S, OP_EFA_S: ssp_ff <= ssp_ff - (word ? 16'h0002 : 16'h0001);
                OP_POP_S: ssp_ff <= ssp_ff + (word ? 16'h0002 : 16'h0001);
                OP_PUSH_U, OP_EFA_U: usp_ff <= usp_ff - (word ? 16'h0002 : 16'h0001);
                OP_POP_U: usp_ff <= usp_ff + (word ? 16'h0002 : 16'h0001);
                default: ssp_ff <= ssp_ff;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            prdata_ff <= 32'h00000000;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            sel_ff <= 1'b0;
        end else begin
            pready_ff <= psel && penable && !pready_ff;
            pslverr_ff <= psel && penable && !pready_ff && !addr_hit;
            sel_ff <= flags_ff[FB_SEL];
            if (rd_go) begin
                case (paddr)
                    OFS_OPA: prdata_ff <= {16'h0000, opa_ff};
                    OFS_OPB: prdata_ff <= {16'h0000, opb_ff};
                    OFS_CMD: prdata_ff <= cmd_ff;
                    OFS_RESULT: prdata_ff <= {16'h0000, result_ff};
                    OFS_FLAGS: prdata_ff <= {24'h000000, flags_ff};
                    OFS_PTR: prdata_ff <= {16'h0000, ptr_ff};
                    OFS_SSP: prdata_ff <= {16'h0000, ssp_ff};
                    OFS_USP: prdata_ff <= {16'h0000, usp_ff};
                    default: prdata_ff <= 32'h00000000;
                endcase
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign memory_space_select = sel_ff;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    sequence cmd_s(op_type o);
        wr_go && paddr == OFS_CMD && op == o && !pwdata[CMD_WORD_BIT];
    endsequence

    byte_add_d_a: assert property (cmd_s(OP_ADD) |=> !flags_ff[FB_D])
        else $error("byte add left decimal flag set");
    byte_sub_d_a: assert property (cmd_s(OP_SUB) |=> flags_ff[FB_D])
        else $error("byte subtract left decimal flag clear");
    logic_carry_a: assert property (cmd_s(OP_AND) |=>
        $stable(flags_ff[FB_C]) && !flags_ff[FB_V])
        else $error("logic op changed carry or overflow");
    shift_left_a: assert property (cmd_s(OP_SHL) |=> !flags_ff[FB_V] && !flags_ff[FB_D])
        else $error("shift left did not clear overflow and decimal");
    rotate_keep_a: assert property (cmd_s(OP_RORC) |=>
        $stable(flags_ff[FB_D]) && $stable(flags_ff[FB_H]))
        else $error("rotate altered decimal or half carry");
    divide_flags_a: assert property (cmd_s(OP_DIV) |=> flags_ff[FB_C] && flags_ff[FB_D])
        else $error("divide did not set carry and decimal");
    bit_op_flags_a: assert property (cmd_s(OP_BXOR) |=> $stable(flags_ff))
        else $error("bit operation changed flags");
    predec_ptr_a: assert property (go && mode == AM_PREDEC && !word
        |=> ptr_ff == $past(ptr_ff) - 16'h0001 && mem_addr_ff == ptr_ff)
        else $error("pre-decrement pointer wrong");
    sel_pin_a: assert property (##1 memory_space_select == $past(flags_ff[FB_SEL]))
        else $error("select pin does not follow flag bit 0");

endmodule

`default_nettype wire

// [core/alu_flags_pkg.sv]
// Constants and types shared by the flag-updating datapath.
package alu_flags_pkg;

    // ------------------------------------------------------------------
    // APB map
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_OPA = 8'h00;
    localparam logic [7:0] OFS_OPB = 8'h04;
    localparam logic [7:0] OFS_CMD = 8'h08;
    localparam logic [7:0] OFS_RESULT = 8'h0C;
    localparam logic [7:0] OFS_FLAGS = 8'h10;
    localparam logic [7:0] OFS_PTR = 8'h14;
    localparam logic [7:0] OFS_SSP = 8'h18;
    localparam logic [7:0] OFS_USP = 8'h1C;

    // ------------------------------------------------------------------
    // Flag register layout and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] FLAG_REG_NUM = 8'hE7;
    localparam int FB_SEL = 0;
    localparam int FB_USER = 1;
    localparam int FB_H = 2;
    localparam int FB_D = 3;
    localparam int FB_V = 4;
    localparam int FB_S = 5;
    localparam int FB_Z = 6;
    localparam int FB_C = 7;
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [15:0] SP_RST = 16'h0000;

    // ------------------------------------------------------------------
    // Command word layout
    // ------------------------------------------------------------------
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_WORD_BIT = 5;
    localparam int CMD_BIT_LSB = 8;
    localparam int CMD_SBIT_LSB = 11;
    localparam int CMD_MODE_LSB = 16;
    localparam int CMD_SMAP_BIT = 20;
    localparam int CMD_DMAP_BIT = 21;

    typedef enum logic [4:0] {
        OP_ADD, OP_ADC, OP_SUB, OP_SUBC, OP_AND, OP_OR, OP_XOR, OP_TM,
        OP_SHL, OP_SHR, OP_RORC, OP_ROLC, OP_DIV, OP_DIVSTEP, OP_BITLD, OP_BAND,
        OP_BOR, OP_BXOR, OP_PUSH_S, OP_POP_S, OP_PUSH_U, OP_POP_U,
        OP_EFA_S, OP_EFA_U, OP_SEL_PROG, OP_SEL_DATA, OP_NOP
    } op_type;

    typedef enum logic [3:0] {
        AM_NONE, AM_POSTINC, AM_PREDEC, AM_M2M, AM_IDX_SHORT, AM_IDX_LONG
    } mode_type;

endpackage

// [test/cpu_alu_flags_addressing_tb.sv]
// Self-checking bench for the flag-updating datapath, driven over APB.
`timescale 1ns/1ps
`default_nettype none
module cpu_alu_flags_addressing_tb
    import alu_flags_pkg::*;
;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic memory_space_select;
    logic [15:0] mem_addr_ff;
    logic src_space_ff;
    logic dst_space_ff;
    int n_fail = 0;
    int num_checks = 0;
    logic [15:0] lf = 16'h596F;
    logic [31:0] rd;
    logic err;

    always #50 clk_sys = ~clk_sys;

    alu_flags_core i_alu_flags_core (.clk_sys(clk_sys), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .memory_space_select(memory_space_select),
        .mem_addr_ff(mem_addr_ff), .src_space_ff(src_space_ff), .dst_space_ff(dst_space_ff));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Returns the expected byte result and flag image; carry rides in bit 8.
    function automatic logic [15:0] model(input op_type op, input logic [7:0] a,
            input logic [7:0] b, input logic [7:0] f, input logic [2:0] n);
        logic [8:0] t;
        logic [7:0] g;
        logic [7:0] r;
        logic ci;
        g = f;
        r = a;
        ci = (op == OP_ADC || op == OP_SUBC || op == OP_RORC || op == OP_ROLC) ? f[FB_C] : 1'b0;
        case (op)
            OP_ADD, OP_ADC: begin
                t = a + b + ci;
                g[FB_H] = (a[3:0] + b[3:0] + ci) > 5'h0F;
                g[FB_V] = (a[7] == b[7]) && (t[7] != a[7]);
                g[FB_D] = 1'b0;
            end
            OP_SUB, OP_SUBC: begin
                t = a - b - ci;
                g[FB_H] = {1'b0, a[3:0]} < (b[3:0] + ci);
                g[FB_V] = (a[7] != b[7]) && (t[7] != a[7]);
                g[FB_D] = 1'b1;
            end
            OP_AND, OP_TM, OP_OR, OP_XOR: begin
                t = {f[FB_C], op == OP_OR ? a | b : op == OP_XOR ? a ^ b : a & b};
                g[FB_V] = 1'b0;
            end
            OP_SHL: begin
                t = {a, 1'b0};
                g[FB_H] = a[3];
                g[FB_V] = 1'b0;
                g[FB_D] = 1'b0;
            end
            OP_SHR: begin
                t = {a[0], a[7], a[7:1]};
                g[FB_D] = 1'b0;
            end
            OP_RORC: t = {a[0], ci, a[7:1]};
            OP_ROLC: t = {a, ci};
            OP_DIV: begin
                t = {1'b1, (b == 8'h00) ? 8'hFF : a / b};
                g[FB_D] = 1'b1;
            end
            OP_BITLD, OP_BAND, OP_BOR, OP_BXOR: begin
                r[n] = (op == OP_BITLD) ? b[n] : (op == OP_BAND) ? (a[n] & b[n]) :
                    (op == OP_BOR) ? (a[n] | b[n]) : (a[n] ^ b[n]);
                return {r, f};
            end
            default: return {8'h00, f};
        endcase
        g[FB_C] = t[8];
        g[FB_Z] = (t[7:0] == 8'h00);
        g[FB_S] = t[7];
        return {t[7:0], g};
    endfunction

    // Result mask in the upper byte, flag mask in the lower; undefined flags are not checked.
    function automatic logic [15:0] masks(input op_type op);
        case (op)
            OP_SHR, OP_DIV: return 16'hFFEB;
            OP_RORC, OP_ROLC: return 16'hFFEF;
            OP_TM: return 16'h00FF;
            default: return 16'hFFFF;
        endcase
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m,
            input string what);
        num_checks++;
        if ((got & m) !== (exp & m)) begin
            n_fail++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got & m, exp & m);
        end
    endtask

    task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= wr_en;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk({31'h0, pready}, 32'h1, 32'h1, "apb answer");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
            input string what);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, m, what);
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    op_type ops[17] = '{OP_ADD, OP_ADC, OP_SUB, OP_SUBC, OP_AND, OP_OR, OP_XOR, OP_TM, OP_SHL,
        OP_SHR, OP_RORC, OP_ROLC, OP_DIV, OP_BITLD, OP_BAND, OP_BOR, OP_BXOR};

    initial begin
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] f;
        logic [15:0] e;
        logic [15:0] m;
        logic [15:0] p;
        logic [15:0] ea;
        logic [15:0] np;
        logic [2:0] bn;
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        rdc(OFS_FLAGS, {24'h0, FLAGS_RST}, 32'hFFFF_FFFF, "flags reset");
        rdc(OFS_PTR, {16'h0, PTR_RST}, 32'hFFFF_FFFF, "ptr reset");
        rdc(OFS_SSP, {16'h0, SP_RST}, 32'hFFFF_FFFF, "ssp reset");
        chk({31'h0, err}, 32'h0, 32'h1, "mapped err");
        for (int i = 0; i < 68; i++) begin
            lf = lfsr_next(lf);
            a = (i < 17) ? 8'h80 : (i < 34) ? 8'h0F : lf[7:0];
            b = (i < 17) ? 8'h80 : (i < 34) ? 8'h01 : lf[15:8];
            lf = lfsr_next(lf);
            f = lf[7:0];
            bn = lf[10:8];
            e = model(ops[i % 17], a, b, f, bn);
            m = masks(ops[i % 17]);
            wr(OFS_OPA, {24'h0, a});
            wr(OFS_OPB, {24'h0, b});
            wr(OFS_FLAGS, {24'h0, f});
            wr(OFS_CMD, {18'h0, bn, bn, 3'h0, ops[i % 17]});
            rdc(OFS_RESULT, {24'h0, e[15:8]}, {24'h0, m[15:8]}, "result");
            rdc(OFS_FLAGS, {24'h0, e[7:0]}, {24'h0, m[7:0]}, "flags");
            chk({31'h0, memory_space_select}, {31'h0, f[0]}, 32'h1, "sel pin");
        end
        for (int k = 0; k < 6; k++) begin
            lf = lfsr_next(lf);
            p = (k == 0) ? 16'hFFFF : (k == 1) ? 16'h0000 : lf;
            ea = k[0] ? p - 16'h1 : p;
            np = k[0] ? p - 16'h1 : p + 16'h1;
            wr(OFS_FLAGS, {31'h0, k[1]});
            wr(OFS_PTR, {16'h0, p});
            wr(OFS_CMD, {12'h0, k[0] ? AM_PREDEC : AM_POSTINC, 11'h0, OP_ADD});
            rdc(OFS_PTR, {16'h0, np}, 32'h0000_FFFF, "ptr step");
            chk({16'h0, mem_addr_ff}, {16'h0, ea}, 32'h0000_FFFF, "access addr");
            chk({30'h0, src_space_ff, dst_space_ff}, {30'h0, k[1], k[1]}, 32'h3, "map");
            wr(OFS_CMD, {10'h0, k[0], ~k[1], AM_M2M, 11'h0, OP_ADD});
            @(posedge clk_sys);
            chk({30'h0, src_space_ff, dst_space_ff}, {30'h0, ~k[1], k[0]}, 32'h3, "m2m");
            rdc(OFS_PTR, {16'h0, np + 16'h1}, 32'h0000_FFFF, "m2m step");
        end
        wr(OFS_OPB, 32'h0000_1280);
        wr(OFS_PTR, 32'h0000_1000);
        for (int x = 0; x < 2; x++) begin
            ea = (x == 0) ? 16'h1080 : 16'h2280;
            wr(OFS_CMD, {12'h0, x == 0 ? AM_IDX_SHORT : AM_IDX_LONG, 16'h0});
            @(posedge clk_sys);
            chk({16'h0, mem_addr_ff}, {16'h0, ea}, 32'h0000_FFFF, "indexed addr");
        end
        rdc(OFS_PTR, 32'h1000, 32'hFFFF, "indexed ptr kept");
        wr(OFS_OPA, 32'h8000);
        wr(OFS_OPB, 32'h8000);
        wr(OFS_FLAGS, 32'h0);
        wr(OFS_CMD, {26'h0, 1'b1, OP_ADD});
        rdc(OFS_RESULT, 32'h0, 32'hFFFF, "word add");
        rdc(OFS_FLAGS, 32'hD0, 32'hF3, "word add flags");
        wr(OFS_OPA, 32'h8001);
        wr(OFS_FLAGS, 32'h08);
        wr(OFS_CMD, {26'h0, 1'b1, OP_SHR});
        rdc(OFS_RESULT, 32'hC000, 32'hFFFF, "word shift");
        rdc(OFS_FLAGS, 32'hA8, 32'hBB, "word shift flags");
        lf = lfsr_next(lf);
        f = lf[7:0];
        wr(OFS_FLAGS, {24'h0, f});
        wr(OFS_SSP, 32'h0000_1000);
        wr(OFS_USP, 32'h0000_2000);
        for (int j = 0; j < 3; j++) begin
            wr(OFS_CMD, {26'h0, 1'b1, j == 0 ? OP_PUSH_S : j == 1 ? OP_PUSH_U : OP_EFA_S});
            rdc(OFS_SSP, j == 1 ? 32'h1000 : 32'h0FFE, 32'hFFFF, "ssp push");
            rdc(OFS_USP, j == 1 ? 32'h1FFE : 32'h2000, 32'hFFFF, "usp kept");
            if (j < 2) begin
                wr(OFS_CMD, {26'h0, 1'b1, j == 0 ? OP_POP_S : OP_POP_U});
                rdc(OFS_SSP, 32'h0000_1000, 32'h0000_FFFF, "ssp pop");
                rdc(OFS_USP, 32'h0000_2000, 32'h0000_FFFF, "usp pop");
            end
        end
        rdc(OFS_FLAGS, {24'h0, f}, 32'h0000_00FF, "stack flags");
        for (int s = 0; s < 2; s++) begin
            wr(OFS_CMD, {27'h0, s == 0 ? OP_SEL_DATA : OP_SEL_PROG});
            rdc(OFS_FLAGS, {31'h0, s == 0}, 32'h1, "sel bit");
            chk({31'h0, memory_space_select}, {31'h0, s == 0}, 32'h1, "sel mirror");
        end
        wr(OFS_OPA, 32'h0000_005A);
        wr(8'h20, 32'h0000_00A5);
        rdc(8'h20, 32'h0, 32'hFFFF_FFFF, "unmapped read");
        chk({31'h0, err}, 32'h1, 32'h1, "unmapped err");
        rdc(OFS_OPA, 32'h0000_005A, 32'h0000_00FF, "unmapped write");
        test_done();
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        $display("[ERR] %0t watchdog expired", $time);
        test_done();
    end
endmodule
`default_nettype wire
